// ### rtl/ddodt_axil.sv
// module: axi4-lite slave front end for the termination register window
module ddodt_axil (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output ddodt_pkg::ddodt_regwr_t regwr,
    output logic [4:0] rd_addr,
    input wire logic [31:0] rd_data
);
    logic aw_held; // write address captured
    logic [31:0] aw_addr;
    logic w_held; // write data captured
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_wr; // both halves present, response slot free

    // one write and one read in flight: ready only while the slot is free
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;
    assign do_wr = aw_held && w_held && !bvalid;
    assign rd_addr = araddr[4:0];

    // address and data halves arrive in either order
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            else if (do_wr)
            begin
                aw_held <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            else if (do_wr)
            begin
                w_held <= 1'b0;
            end
        end
    end

    // write response, unmapped words answer slverr
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp <= ddodt_pkg::DDODT_RESP_OKAY;
        end
        else if (do_wr)
        begin
            bvalid <= 1'b1;
            bresp <= ddodt_pkg::ddodt_hit(aw_addr) ? ddodt_pkg::DDODT_RESP_OKAY
                                                   : ddodt_pkg::DDODT_RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // read channel, data captured at the address handshake
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= ddodt_pkg::DDODT_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= ddodt_pkg::ddodt_hit(araddr) ? rd_data : 32'h0000_0000;
            rresp <= ddodt_pkg::ddodt_hit(araddr) ? ddodt_pkg::DDODT_RESP_OKAY
                                                  : ddodt_pkg::DDODT_RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    // write strobe towards the register file
    always_comb
    begin
        regwr.en = do_wr && ddodt_pkg::ddodt_hit(aw_addr);
        regwr.addr = aw_addr[4:0];
        regwr.data = w_data;
        regwr.strb = w_strb;
    end
endmodule : ddodt_axil

// ### rtl/ddodt_pkg.sv
// package: register map, field layout, latency figures and carrier types
package ddodt_pkg;
    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [4:0] DDODT_OFS_MR1 = 5'h00;
    localparam logic [4:0] DDODT_OFS_MR2 = 5'h04;
    localparam logic [4:0] DDODT_OFS_MR5 = 5'h08;
    localparam logic [4:0] DDODT_OFS_CFG = 5'h0C;
    localparam logic [4:0] DDODT_OFS_STAT = 5'h10;
    // field positions
    localparam int DDODT_NOM_LSB = 8;
    localparam int DDODT_WR_LSB = 9;
    localparam int DDODT_PARK_LSB = 6;
    localparam int DDODT_CWL_LSB = 0;
    localparam int DDODT_AL_LSB = 8;
    localparam int DDODT_PL_LSB = 16;
    localparam int DDODT_PRE2_BIT = 24;
    localparam int DDODT_CRC_BIT = 25;
    localparam int DDODT_DLLOFF_BIT = 26;
    localparam int DDODT_BL_LSB = 28;
    // reset values
    localparam logic [31:0] DDODT_MR_RST = 32'h0000_0000;
    localparam logic [31:0] DDODT_CFG_RST = 32'h0000_0009;
    // burst length modes
    localparam logic [1:0] DDODT_BL_FIX8 = 2'h0;
    localparam logic [1:0] DDODT_BL_OTF = 2'h1;
    localparam logic [1:0] DDODT_BL_FIX4 = 2'h2;
    // latency figures in clocks
    localparam logic [6:0] DDODT_SUB_1CK = 7'h02;
    localparam logic [6:0] DDODT_SUB_2CK = 7'h03;
    localparam logic [6:0] DDODT_CWN4_1 = 7'h04;
    localparam logic [6:0] DDODT_CWN4_1C = 7'h07;
    localparam logic [6:0] DDODT_CWN4_2 = 7'h05;
    localparam logic [6:0] DDODT_CWN4_2C = 7'h08;
    localparam logic [6:0] DDODT_CWN8_1 = 7'h06;
    localparam logic [6:0] DDODT_CWN8_1C = 7'h07;
    localparam logic [6:0] DDODT_CWN8_2 = 7'h07;
    localparam logic [6:0] DDODT_CWN8_2C = 7'h08;
    // bus responses
    localparam logic [1:0] DDODT_RESP_OKAY = 2'h0;
    localparam logic [1:0] DDODT_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {DDODT_PARK, DDODT_NOM, DDODT_WR} ddodt_rtt_t;

    typedef struct packed {
        logic en;
        logic [4:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } ddodt_regwr_t;

    typedef struct packed {
        logic [5:0] cwl;
        logic [5:0] al;
        logic [3:0] pl;
        logic pre2;
        logic crc;
        logic dll_off;
        logic [1:0] bl;
    } ddodt_cfg_t;

    // mapped word of the register window
    function automatic logic ddodt_hit(input logic [31:0] a);
        ddodt_hit = (a[31:5] == 27'h0000000) && (a[1:0] == 2'h0) && (a[4:0] <= DDODT_OFS_STAT);
    endfunction : ddodt_hit
endpackage : ddodt_pkg

// ### rtl/ddodt_tap.sv
// module: odt pin delay line with a selectable tap
module ddodt_tap #(
    parameter int DEPTH = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    input wire logic [6:0] lat,
    output logic q
);
    logic [DEPTH-1:0] sh; // sh[n] holds the pin as sampled n+1 edges ago
    logic [6:0] idx; // tap index, clamped to the line

    // shift line, one sample per clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sh <= '0;
        end
        else
        begin
            sh <= {sh[DEPTH-2:0], d};
        end
    end

    // a latency of n is read one stage early because the caller registers it
    always_comb
    begin
        if (int'(lat) > DEPTH)
        begin
            idx = 7'(DEPTH - 1);
        end
        else
        begin
            idx = lat - 7'h01;
        end
        q = sh[idx[5:0]];
    end
endmodule : ddodt_tap

// ### rtl/ddodt_top.sv
// module: termination select for nominal, write and park values
// Notes on behaviour
// - dynamic mode on when write field nonzero
// - nominal value from mode register 1 bits 10:8
// - write value from mode register 2 bits 11:9
// - park value from mode register 5 bits 8:6
// - idle: pin drives nominal, park while low
// - with dynamic mode on and DLL on, every registered write starts write termination
// - write select after WL-2 or WL-3 clocks
// - chop-4 deselect offset 4, 7, 5, 8
// - burst-8 deselect offset 6, 7, 7, 8
// - chop versus burst from mode or command
// - no write switching with DLL off
// - DLL off means asynchronous pin mode
// - asynchronous mode adds no AL or PL
// - asynchronous: pin high moves park to nominal
// - asynchronous: pin low moves nominal to park
// - pin latency CWL+AL+PL minus 2 or 3
// - write window overrides the pin; DLL off overrides the write window
module ddodt_top #(
    parameter int LAT_DEPTH = 64
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic ODT,
    input wire logic WR_CMD,
    input wire logic WR_BC4,
    output ddodt_pkg::ddodt_rtt_t RTT_SEL,
    output logic [2:0] RTT_CODE,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // ************************************************************
    // register window
    // ************************************************************
    ddodt_pkg::ddodt_regwr_t regwr; // write strobe from the slave
    logic [4:0] rd_addr; // read word selector
    logic [31:0] rd_data; // read word
    logic [31:0] mr1; // nominal value image
    logic [31:0] mr2; // write value image
    logic [31:0] mr5; // park value image
    logic [31:0] cfg_word; // latency and mode settings
    ddodt_pkg::ddodt_cfg_t cfg; // decoded settings

    ddodt_axil u_axil (
        .clk(CLOCK),
        .rst(SYS_RST),
        .awaddr(S_AXI_AWADDR),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .regwr(regwr),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // byte-lane merge, shared by every writable word
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        for (int i = 0; i < 4; i++)
        begin
            merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    // register file; the status word ignores writes
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            mr1 <= ddodt_pkg::DDODT_MR_RST;
            mr2 <= ddodt_pkg::DDODT_MR_RST;
            mr5 <= ddodt_pkg::DDODT_MR_RST;
            cfg_word <= ddodt_pkg::DDODT_CFG_RST;
        end
        else if (regwr.en)
        begin
            case (regwr.addr)
                ddodt_pkg::DDODT_OFS_MR1: mr1 <= merge(mr1, regwr.data, regwr.strb);
                ddodt_pkg::DDODT_OFS_MR2: mr2 <= merge(mr2, regwr.data, regwr.strb);
                ddodt_pkg::DDODT_OFS_MR5: mr5 <= merge(mr5, regwr.data, regwr.strb);
                ddodt_pkg::DDODT_OFS_CFG: cfg_word <= merge(cfg_word, regwr.data, regwr.strb);
                default: ; // status or gap: nothing stored
            endcase
        end
    end

    // settings fields
    always_comb
    begin
        cfg.cwl = cfg_word[ddodt_pkg::DDODT_CWL_LSB +: 6];
        cfg.al = cfg_word[ddodt_pkg::DDODT_AL_LSB +: 6];
        cfg.pl = cfg_word[ddodt_pkg::DDODT_PL_LSB +: 4];
        cfg.pre2 = cfg_word[ddodt_pkg::DDODT_PRE2_BIT];
        cfg.crc = cfg_word[ddodt_pkg::DDODT_CRC_BIT];
        cfg.dll_off = cfg_word[ddodt_pkg::DDODT_DLLOFF_BIT];
        cfg.bl = cfg_word[ddodt_pkg::DDODT_BL_LSB +: 2];
    end

    // ************************************************************
    // termination values and latencies
    // ************************************************************
    logic [2:0] nom_val; // nominal termination code
    logic [2:0] wr_val; // write termination code
    logic [2:0] park_val; // park termination code
    logic dyn_en; // dynamic mode enabled
    logic [6:0] wl; // write latency
    logic [6:0] sub; // preamble correction
    logic [6:0] lat_cnw; // write-select latency
    logic [6:0] lat_cwn; // write-deselect latency
    logic [6:0] lat_dodt; // pin latency, at least one clock
    logic bc4_now; // this write is a chop

    assign nom_val = mr1[ddodt_pkg::DDODT_NOM_LSB +: 3];
    assign wr_val = mr2[ddodt_pkg::DDODT_WR_LSB +: 3];
    assign park_val = mr5[ddodt_pkg::DDODT_PARK_LSB +: 3];
    assign dyn_en = |wr_val; // any of A9, A10 or A11 set

    // deselect offset after select, by burst, preamble and crc
    function automatic logic [6:0] cwn_add(input logic bc4, input logic pre2, input logic crc);
        case ({bc4, pre2, crc})
            3'h4: cwn_add = ddodt_pkg::DDODT_CWN4_1;
            3'h5: cwn_add = ddodt_pkg::DDODT_CWN4_1C;
            3'h6: cwn_add = ddodt_pkg::DDODT_CWN4_2;
            3'h7: cwn_add = ddodt_pkg::DDODT_CWN4_2C;
            3'h0: cwn_add = ddodt_pkg::DDODT_CWN8_1;
            3'h1: cwn_add = ddodt_pkg::DDODT_CWN8_1C;
            3'h2: cwn_add = ddodt_pkg::DDODT_CWN8_2;
            default: cwn_add = ddodt_pkg::DDODT_CWN8_2C;
        endcase
    endfunction : cwn_add

    // latency arithmetic; a setting below the correction wraps, software must avoid it
    always_comb
    begin
        wl = 7'(cfg.cwl) + 7'(cfg.al) + 7'(cfg.pl);
        sub = cfg.pre2 ? ddodt_pkg::DDODT_SUB_2CK : ddodt_pkg::DDODT_SUB_1CK;
        lat_cnw = wl - sub;
        // fixed chop, or on-the-fly chop picked by the command
        bc4_now = (cfg.bl == ddodt_pkg::DDODT_BL_FIX4)
               || ((cfg.bl == ddodt_pkg::DDODT_BL_OTF) && WR_BC4);
        lat_cwn = lat_cnw + cwn_add(bc4_now, cfg.pre2, cfg.crc);
        // pin latency shares the select figure
        lat_dodt = (lat_cnw == 7'h00) ? 7'h01 : lat_cnw;
    end

    // ************************************************************
    // write window schedule
    // ************************************************************
    // bit n of the schedule says: write value selected n edges from now
    logic [LAT_DEPTH-1:0] fut;
    logic [LAT_DEPTH-1:0] next_fut;
    logic dyn_go; // this write opens a window

    // window of one write: bits lo up to hi-1
    function automatic logic [LAT_DEPTH-1:0] win_mask(input logic [6:0] lo, input logic [6:0] hi);
        for (int i = 0; i < LAT_DEPTH; i++)
        begin
            win_mask[i] = (i >= int'(lo)) && (i < int'(hi));
        end
    endfunction : win_mask

    // dll off kills the schedule outright
    assign dyn_go = WR_CMD && dyn_en && !cfg.dll_off;

    // windows are or-ed, so a later write stretches to its own end
    always_comb
    begin
        next_fut = fut >> 1;
        if (dyn_go)
        begin
            next_fut = next_fut | win_mask(lat_cnw, lat_cwn);
        end
        if (cfg.dll_off)
        begin
            next_fut = '0;
        end
    end

    // schedule register
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            fut <= '0;
        end
        else
        begin
            fut <= next_fut;
        end
    end

    // ************************************************************
    // pin path and output select
    // ************************************************************
    logic odt_tap; // pin, delayed by the direct latency less one
    ddodt_pkg::ddodt_rtt_t next_sel;
    logic [2:0] next_code;

    ddodt_tap #(
        .DEPTH(LAT_DEPTH)
    ) u_tap (
        .clk(CLOCK),
        .rst(SYS_RST),
        .d(ODT),
        .lat(lat_dodt),
        .q(odt_tap)
    );

    // choose the value; the write window outranks the pin
    always_comb
    begin
        if (cfg.dll_off)
        begin
            // pin taken as sampled, no AL or PL
            next_sel = ODT ? ddodt_pkg::DDODT_NOM : ddodt_pkg::DDODT_PARK;
        end
        else if (next_fut[0])
        begin
            next_sel = ddodt_pkg::DDODT_WR;
        end
        else
        begin
            // direct latency path, also the return after a window
            next_sel = odt_tap ? ddodt_pkg::DDODT_NOM : ddodt_pkg::DDODT_PARK;
        end
        case (next_sel)
            ddodt_pkg::DDODT_NOM: next_code = nom_val;
            ddodt_pkg::DDODT_WR: next_code = wr_val;
            default: next_code = park_val;
        endcase
    end

    // registered outputs, park after reset
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RTT_SEL <= ddodt_pkg::DDODT_PARK;
            RTT_CODE <= 3'h0;
        end
        else
        begin
            RTT_SEL <= next_sel;
            RTT_CODE <= next_code;
        end
    end

    // read mux; the status word shows live termination state
    always_comb
    begin
        case (rd_addr)
            ddodt_pkg::DDODT_OFS_MR1: rd_data = mr1;
            ddodt_pkg::DDODT_OFS_MR2: rd_data = mr2;
            ddodt_pkg::DDODT_OFS_MR5: rd_data = mr5;
            ddodt_pkg::DDODT_OFS_CFG: rd_data = cfg_word;
            ddodt_pkg::DDODT_OFS_STAT: rd_data = {18'h00000, lat_cnw, |fut, dyn_en,
                                                  RTT_CODE, RTT_SEL};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // checks
    // ************************************************************
    // helper: age of the last write and the figures it was given
    logic [6:0] age;
    logic armed;
    logic single;
    logic [6:0] q_cnw;
    logic [6:0] q_cwn;

    // helper tracking; only the checks read it
    always_ff @(posedge CLOCK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            age <= 7'h7F;
            armed <= 1'b0;
            single <= 1'b0;
            q_cnw <= 7'h00;
            q_cwn <= 7'h00;
        end
        else if (WR_CMD)
        begin
            age <= 7'h00;
            armed <= dyn_go;
            single <= (fut == '0);
            q_cnw <= lat_cnw;
            q_cwn <= lat_cwn;
        end
        else
        begin
            age <= (age == 7'h7F) ? age : age + 7'h01;
            armed <= armed && !cfg.dll_off && !regwr.en;
        end
    end

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    nom_value_a: assert property (RTT_SEL == ddodt_pkg::DDODT_NOM |-> RTT_CODE == $past(nom_val))
        else $error("nominal code mismatch");
    wr_value_a: assert property (RTT_SEL == ddodt_pkg::DDODT_WR |-> RTT_CODE == $past(wr_val))
        else $error("write code mismatch");
    park_value_a: assert property (RTT_SEL == ddodt_pkg::DDODT_PARK |-> RTT_CODE == $past(park_val))
        else $error("park code mismatch");
    wr_idle_a: assert property ((fut == '0) && !dyn_go |=> RTT_SEL != ddodt_pkg::DDODT_WR)
        else $error("write value without a window");
    wr_select_a: assert property (armed && (age == q_cnw) |-> RTT_SEL == ddodt_pkg::DDODT_WR)
        else $error("write value not selected on time");
    wr_deselect_a: assert property (armed && single && (age == q_cwn)
        |-> RTT_SEL != ddodt_pkg::DDODT_WR)
        else $error("write value held past its window");
    wr_return_a: assert property ($fell(RTT_SEL == ddodt_pkg::DDODT_WR) && !$past(cfg.dll_off)
        |-> RTT_SEL == ($past(odt_tap) ? ddodt_pkg::DDODT_NOM : ddodt_pkg::DDODT_PARK))
        else $error("wrong value after write window");
    dll_off_a: assert property (cfg.dll_off && $past(cfg.dll_off)
        |-> RTT_SEL != ddodt_pkg::DDODT_WR)
        else $error("write switching with dll off");
    async_on_a: assert property (cfg.dll_off ##1 cfg.dll_off && $past(ODT)
        |-> RTT_SEL == ddodt_pkg::DDODT_NOM)
        else $error("async turn-on missed");
    async_off_a: assert property (cfg.dll_off ##1 cfg.dll_off && !$past(ODT)
        |-> RTT_SEL == ddodt_pkg::DDODT_PARK)
        else $error("async turn-off missed");
    sync_pin_a: assert property (!cfg.dll_off && !next_fut[0] |=>
        RTT_SEL == ($past(odt_tap) ? ddodt_pkg::DDODT_NOM : ddodt_pkg::DDODT_PARK))
        else $error("direct latency path wrong");

    bl8_write_c: cover property (dyn_go && !bc4_now ##1 !WR_CMD [*8]);
    bc4_write_c: cover property (dyn_go && bc4_now);
    overlap_c: cover property (dyn_go && (fut != '0));
    async_c: cover property (cfg.dll_off && $rose(ODT));
endmodule : ddodt_top

// ### verification/ddodt_ctrl_model.sv
// controller-side model: drives the odt pin and write commands
module ddodt_ctrl_model (
    input wire logic clk,
    output logic odt,
    output logic wr_cmd,
    output logic wr_bc4
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins idle low from time zero
    initial
    begin
        odt = 1'b0;
        wr_cmd = 1'b0;
        wr_bc4 = 1'b0;
    end
    // one-cycle command; returns at the edge that registers it
    task automatic write_cmd(input logic bc4);
        @(posedge clk);
        wr_cmd <= 1'b1;
        wr_bc4 <= bc4;
        @(posedge clk);
        wr_cmd <= 1'b0;
        wr_bc4 <= ~bc4; // qualifier is junk outside a command
    endtask : write_cmd
    // pin level, sampled at the next edge
    task automatic set_odt(input logic v);
        @(posedge clk);
        odt <= v;
    endtask : set_odt
endmodule : ddodt_ctrl_model

// ### verification/ddodt_top_tb_top.sv
// testbench: termination select through its pins and register bus
module ddodt_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, sys_rst = 1'b1, awv, wv, bready;
    logic arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid, odt, wr_cmd, wr_bc4;
    logic [31:0] awaddr, wdata, araddr, rdata, d, cfg;
    logic [3:0] strb; // write lanes, all on except in the lane-merge case
    logic [1:0] bresp, rresp, r;
    logic [2:0] pc, nc, wc;
    ddodt_pkg::ddodt_rtt_t rtt_sel;
    logic [2:0] rtt_code;
    int fails = 0, checked = 0, cnw, m, seed;
    logic bc4, al, pl;
    ddodt_top ddodt_top_i (.CLOCK(clock), .SYS_RST(sys_rst), .ODT(odt), .WR_CMD(wr_cmd),
        .WR_BC4(wr_bc4), .RTT_SEL(rtt_sel), .RTT_CODE(rtt_code), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    ddodt_ctrl_model ddodt_ctrl_model_i (.clk(clock), .odt(odt), .wr_cmd(wr_cmd),
        .wr_bc4(wr_bc4));
    // 25 MHz clock
    always #20 clock = ~clock;
    // ************************************************************
    // bus and compare helpers
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // address and data offered together, each dropped once taken
    task automatic axw(input logic [31:0] a, input logic [31:0] v);
        @(posedge clock);
        {awaddr, wdata, awv, wv, bready} <= {a, v, 3'h7};
        do
        begin
            @(posedge clock);
            if (awrdy) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (bvalid !== 1'b1);
        chk("bresp", 32'(ddodt_pkg::DDODT_RESP_OKAY), 32'(bresp));
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [31:0] a);
        @(posedge clock);
        {araddr, arv, rready} <= {a, 2'h3};
        do
        begin
            @(posedge clock);
            if (arrdy) arv <= 1'b0;
        end while (rvalid !== 1'b1);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : axr
    // deselect offset from chop flag and {two-clock preamble, crc}
    function automatic int off_of(input logic c, input logic [1:0] p);
        off_of = c ? (p == 0 ? 4 : p == 1 ? 7 : p == 2 ? 5 : 8) : (p == 0 ? 6 : p == 3 ? 8 : 7);
    endfunction : off_of
    // selection after edges 1..n: in_v inside [lo,hi), out_v elsewhere
    task automatic win(input int n, input int lo, input int hi,
        input ddodt_pkg::ddodt_rtt_t in_v, input ddodt_pkg::ddodt_rtt_t out_v);
        ddodt_pkg::ddodt_rtt_t e;
        for (int k = 1; k <= n; k++)
        begin
            @(posedge clock);
            #1;
            e = (k >= lo && k < hi) ? in_v : out_v;
            chk("rtt_sel", e, rtt_sel);
            chk("rtt_code", e == ddodt_pkg::DDODT_WR ? wc : e == ddodt_pkg::DDODT_NOM ? nc : pc,
                rtt_code);
        end
    endtask : win
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        seed = 32'hDE6D16A5;
        // bus idle, all lanes on, while reset is held
        {awaddr, wdata, araddr, strb, awv, wv, bready, arv, rready} <= {96'h0, 4'hF, 5'h00};
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        axr(32'h0000000C);
        chk("cfg", ddodt_pkg::DDODT_CFG_RST, d);
        axr(32'h00000020);
        chk("rresp", ddodt_pkg::DDODT_RESP_SLVERR, r);
        {pc, nc, wc} = 9'($random(seed));
        wc[0] = 1'b1; // keeps the write field nonzero
        axw(32'h0, 32'(nc) << 8);
        // lane 0 only: the nominal field in lane 1 must survive
        strb <= 4'h1;
        axw(32'h0, 32'hFFFF_FFFF);
        strb <= 4'hF;
        axr(32'h0);
        chk("mr1", (32'(nc) << 8) | 32'hFF, d);
        axw(32'h4, 32'(wc) << 9);
        axw(32'h8, 32'(pc) << 6);
        axr(32'h4);
        chk("mr2", 32'(wc) << 9, d);
        // every preamble, crc and burst mode, random additive latency
        for (int i = 0; i < 12; i++)
        begin
            {pl, al, bc4} = 3'($random(seed));
            m = i >> 2;
            cfg = 32'h9 | (32'(al) << 8) | (32'(pl) << 16);
            cfg = cfg | (32'(i & 3) << 24) | (32'(m) << 28);
            cnw = 9 + al + pl - (i[0] ? 3 : 2);
            axw(32'hC, cfg);
            ddodt_ctrl_model_i.write_cmd(bc4);
            win(cnw + 10, cnw, cnw + off_of(m == 2 || (m == 1 && bc4), {i[0], i[1]}),
                ddodt_pkg::DDODT_WR, ddodt_pkg::DDODT_PARK);
        end
        axw(32'hC, 32'h9);
        ddodt_ctrl_model_i.set_odt(1'b1);
        win(9, 8, 99, ddodt_pkg::DDODT_NOM, ddodt_pkg::DDODT_PARK);
        ddodt_ctrl_model_i.write_cmd(1'b0);
        ddodt_ctrl_model_i.write_cmd(1'b0);
        win(16, 5, 13, ddodt_pkg::DDODT_WR, ddodt_pkg::DDODT_NOM);
        ddodt_ctrl_model_i.set_odt(1'b0);
        win(9, 8, 99, ddodt_pkg::DDODT_PARK, ddodt_pkg::DDODT_NOM);
        axw(32'h4, 32'h0);
        ddodt_ctrl_model_i.write_cmd(1'b0);
        win(16, 99, 99, ddodt_pkg::DDODT_WR, ddodt_pkg::DDODT_PARK);
        axw(32'h4, 32'(wc) << 9);
        axw(32'hC, 32'h0400_0109);
        ddodt_ctrl_model_i.set_odt(1'b1);
        win(3, 1, 99, ddodt_pkg::DDODT_NOM, ddodt_pkg::DDODT_PARK);
        ddodt_ctrl_model_i.write_cmd(1'b1);
        win(14, 99, 99, ddodt_pkg::DDODT_WR, ddodt_pkg::DDODT_NOM);
        ddodt_ctrl_model_i.set_odt(1'b0);
        win(3, 1, 99, ddodt_pkg::DDODT_PARK, ddodt_pkg::DDODT_NOM);
        tally_and_finish();
    end
    // watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        tally_and_finish();
    end
endmodule : ddodt_top_tb_top
